// File: common/lsc_regs.svh
// register offsets, field positions and reset values of the regulator state controls
// assumes an 8-bit register port with byte addresses
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH
`define LSC_IMG_A_ADDR 8'h42
`define LSC_CORE_ADDR 8'h44
`define LSC_IMG_A_RST 8'h04
`define LSC_CORE_RST 8'h3c
`define LSC_STATE_LSB 0
`define LSC_STATE_MSB 2
`define LSC_EXIT_LSB 3
`define LSC_EXIT_MSB 5
`define LSC_LIVE_MASK 8'h3f
`define LSC_CODE_OFF 3'h4
`define LSC_CODE_LOW 3'h5
`endif

// File: common/lsc_pkg.sv
// types shared by the regulator state control
// assumes lsc_regs.svh for numeric constants
package lsc_pkg;
    typedef enum logic [1:0] {
        LSC_MODE_NONE = 2'b00,
        LSC_MODE_OFF = 2'b01,
        LSC_MODE_LOW = 2'b11,
        LSC_MODE_ACT = 2'b10
    } lsc_mode_t;
endpackage

// File: common/lsc_ctl_if.sv
// carries one regulator control register between top and decoder
// assumes the top drives reg_val and reads the decoded mode
interface lsc_ctl_if;
    logic [7:0] reg_val;
    lsc_pkg::lsc_mode_t cur_mode;
    lsc_pkg::lsc_mode_t exit_mode;
    modport top (output reg_val, input cur_mode, input exit_mode);
    modport dec (input reg_val, output cur_mode, output exit_mode);
endinterface

// File: core/lsc_decode.sv
// decodes the state and exit-state fields of one regulator register
// assumes a register value stable in the caller's clock domain
`include "lsc_regs.svh"
module lsc_decode
    import lsc_pkg::*;
(
    lsc_ctl_if.dec ctl
);
    function automatic lsc_mode_t lsc_code_mode(input logic [2:0] code);
        if (code == `LSC_CODE_OFF)
            return LSC_MODE_OFF;
        else if (code == `LSC_CODE_LOW)
            return LSC_MODE_LOW;
        else if (code[2])
            return LSC_MODE_ACT;
        else
            return LSC_MODE_NONE;
    endfunction

    assign ctl.cur_mode = lsc_code_mode(ctl.reg_val[`LSC_STATE_MSB:`LSC_STATE_LSB]); // [RULE1]
    assign ctl.exit_mode = lsc_code_mode(ctl.reg_val[`LSC_EXIT_MSB:`LSC_EXIT_LSB]); // [RULE2]
endmodule // lsc_decode

// File: core/lsc_ldo_ctrl.sv
// state control registers of the core and imaging regulators
// assumes a byte-wide register port on mclk and an asynchronous exit pin
//
// Behaviour
// RULE1 - state codes 4 off, 5 low power, 6 and 7 active, 0 to 3 select no state.
// RULE2 - the standby exit pin loads each state field from its exit field unless that is 0 to 3.
// RULE3 - the host loads the exit fields after power up before relying on standby exit.
// RULE4 - the core register sits at 0x44, reads and writes, resets to 0x3c, top bits reserved.
// RULE5 - the imaging register sits at 0x42, reads and writes, resets to 0x04, top bits reserved.
// RULE6 - the imaging regulator's discharge path is on whenever it is off.
// RULE7 - reserved bits 7:6 ignore writes and read as zero.
`include "lsc_regs.svh"
module lsc_ldo_ctrl
    import lsc_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_ff,
    output logic reg_hit_ff,
    // pins
    input wire logic standby_exit_pin,
    // regulator controls
    output lsc_mode_t core_ldo_mode_ff,
    output lsc_mode_t imaging_ldo_a_mode_ff,
    output logic imaging_ldo_a_discharge_ff
);
    // ------------------------------------------------
    // registers and decoders
    // ------------------------------------------------
    logic [7:0] core_ldo_control_ff;
    logic [7:0] imaging_ldo_a_control_ff;
    logic [7:0] nxt_core;
    logic [7:0] nxt_img;
    logic exit_s1_ff;
    logic exit_s2_ff;
    logic exit_d_ff;
    logic exit_rise;
    lsc_ctl_if core_if ();
    lsc_ctl_if img_if ();

    assign core_if.reg_val = core_ldo_control_ff;
    assign img_if.reg_val = imaging_ldo_a_control_ff;

    lsc_decode u_core_dec (.ctl(core_if));
    lsc_decode u_img_dec (.ctl(img_if));

    // ------------------------------------------------
    // exit pin synchroniser
    // ------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            exit_s1_ff <= 1'b0;
            exit_s2_ff <= 1'b0;
            exit_d_ff <= 1'b0;
        end else if (clk_en) begin
            exit_s1_ff <= standby_exit_pin;
            exit_s2_ff <= exit_s1_ff;
            exit_d_ff <= exit_s2_ff;
        end
    end

    assign exit_rise = exit_s2_ff & ~exit_d_ff;

    // ------------------------------------------------
    // register update
    // ------------------------------------------------
    function automatic logic [7:0] lsc_next(input logic [7:0] cur, input logic wr,
                                             input logic [7:0] wd, input logic ex);
        logic [7:0] v;
        v = cur;
        if (wr)
            v = wd & `LSC_LIVE_MASK; // [RULE7]
        // exit codes 0 to 3 have a clear top bit; a same-cycle write decides
        if (ex && v[`LSC_EXIT_MSB])
            v[`LSC_STATE_MSB:`LSC_STATE_LSB] = v[`LSC_EXIT_MSB:`LSC_EXIT_LSB]; // [RULE2]
        return v;
    endfunction

    always_comb begin
        nxt_core = lsc_next(core_ldo_control_ff, reg_wr && reg_addr == `LSC_CORE_ADDR,
                            reg_wdata, exit_rise);
        nxt_img = lsc_next(imaging_ldo_a_control_ff, reg_wr && reg_addr == `LSC_IMG_A_ADDR,
                           reg_wdata, exit_rise);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            core_ldo_control_ff <= `LSC_CORE_RST; // [RULE4]
            imaging_ldo_a_control_ff <= `LSC_IMG_A_RST; // [RULE5]
        end else if (clk_en) begin
            core_ldo_control_ff <= nxt_core; // [RULE4]
            imaging_ldo_a_control_ff <= nxt_img; // [RULE5]
        end
    end

    // ------------------------------------------------
    // read port
    // ------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata_ff <= 8'h00;
            reg_hit_ff <= 1'b0;
        end else if (clk_en) begin
            if (reg_rd && reg_addr == `LSC_CORE_ADDR) begin
                reg_rdata_ff <= core_ldo_control_ff & `LSC_LIVE_MASK; // [RULE7]
                reg_hit_ff <= 1'b1;
            end else if (reg_rd && reg_addr == `LSC_IMG_A_ADDR) begin
                reg_rdata_ff <= imaging_ldo_a_control_ff & `LSC_LIVE_MASK; // [RULE7]
                reg_hit_ff <= 1'b1;
            end else begin
                reg_rdata_ff <= 8'h00;
                reg_hit_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------
    // regulator outputs
    // ------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            core_ldo_mode_ff <= LSC_MODE_OFF;
            imaging_ldo_a_mode_ff <= LSC_MODE_OFF;
            imaging_ldo_a_discharge_ff <= 1'b1;
        end else if (clk_en) begin
            core_ldo_mode_ff <= core_if.cur_mode; // [RULE1]
            imaging_ldo_a_mode_ff <= img_if.cur_mode; // [RULE1]
            imaging_ldo_a_discharge_ff <= (img_if.cur_mode == LSC_MODE_OFF); // [RULE6]
        end
    end

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    sequence img_copy_s;
        exit_rise && clk_en && !reg_wr && img_if.exit_mode != LSC_MODE_NONE;
    endsequence

    sequence core_copy_s;
        exit_rise && clk_en && !reg_wr && core_if.exit_mode != LSC_MODE_NONE;
    endsequence

    sequence core_wr_s;
        clk_en && reg_wr && reg_addr == `LSC_CORE_ADDR && !exit_rise;
    endsequence

    sequence img_wr_s;
        clk_en && reg_wr && reg_addr == `LSC_IMG_A_ADDR && !exit_rise;
    endsequence

    sequence img_wr_exit_s;
        clk_en && reg_wr && reg_addr == `LSC_IMG_A_ADDR && exit_rise;
    endsequence

    sequence core_rd_s;
        clk_en && reg_rd && reg_addr == `LSC_CORE_ADDR;
    endsequence

    sequence img_rd_s;
        clk_en && reg_rd && reg_addr == `LSC_IMG_A_ADDR;
    endsequence

    sequence no_hit_s;
        clk_en && !(reg_rd && (reg_addr == `LSC_CORE_ADDR || reg_addr == `LSC_IMG_A_ADDR));
    endsequence

    rsv_zero_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE7]
        core_ldo_control_ff[7:6] == 2'b00 && imaging_ldo_a_control_ff[7:6] == 2'b00)
        else $error("reserved bits not zero");
    exit_copy_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
        img_copy_s |=> imaging_ldo_a_control_ff[2:0] == $past(imaging_ldo_a_control_ff[5:3]))
        else $error("exit state not copied");
    core_copy_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
        core_copy_s |=> core_ldo_control_ff[2:0] == $past(core_ldo_control_ff[5:3]))
        else $error("core exit state not copied");
    exit_nocopy_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
        clk_en && !reg_wr && core_if.exit_mode == LSC_MODE_NONE |=>
            $stable(core_ldo_control_ff))
        else $error("exit copy with reserved code");
    img_nocopy_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
        clk_en && !reg_wr && img_if.exit_mode == LSC_MODE_NONE |=>
            $stable(imaging_ldo_a_control_ff))
        else $error("imaging exit copy with reserved code");
    wr_copy_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
        img_wr_exit_s ##0 reg_wdata[`LSC_EXIT_MSB] |=>
            imaging_ldo_a_control_ff[2:0] == $past(reg_wdata[5:3]))
        else $error("written exit state not copied");
    wr_keep_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
        img_wr_exit_s ##0 !reg_wdata[`LSC_EXIT_MSB] |=>
            imaging_ldo_a_control_ff[2:0] == $past(reg_wdata[2:0]))
        else $error("reserved exit code copied");
    core_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE4]
        core_wr_s |=> core_ldo_control_ff == ($past(reg_wdata) & `LSC_LIVE_MASK))
        else $error("core write lost");
    img_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE5]
        img_wr_s |=> imaging_ldo_a_control_ff == ($past(reg_wdata) & `LSC_LIVE_MASK))
        else $error("imaging write lost");
    core_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE4]
        core_rd_s |=> reg_hit_ff && reg_rdata_ff == $past(core_ldo_control_ff))
        else $error("core read wrong");
    img_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE5]
        img_rd_s |=> reg_hit_ff && reg_rdata_ff == $past(imaging_ldo_a_control_ff))
        else $error("imaging read wrong");
    read_miss_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE4] [RULE5]
        no_hit_s |=> !reg_hit_ff && reg_rdata_ff == 8'h00)
        else $error("unmapped read answered");
    core_decode_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE1]
        clk_en && core_ldo_control_ff[2:1] == 2'b11 |=> core_ldo_mode_ff == LSC_MODE_ACT)
        else $error("core active code misdecoded");
    core_off_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE1]
        clk_en && core_ldo_control_ff[2:0] == `LSC_CODE_OFF |=>
            core_ldo_mode_ff == LSC_MODE_OFF)
        else $error("core off code misdecoded");
    img_decode_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE1]
        clk_en && imaging_ldo_a_control_ff[2:0] == `LSC_CODE_LOW |=>
            imaging_ldo_a_mode_ff == LSC_MODE_LOW)
        else $error("low power misdecoded");
    img_rsvd_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE1]
        clk_en && !imaging_ldo_a_control_ff[2] |=> imaging_ldo_a_mode_ff == LSC_MODE_NONE)
        else $error("reserved state code selected a state");
    img_dis_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE6]
        clk_en && img_if.cur_mode == LSC_MODE_OFF |=> imaging_ldo_a_discharge_ff)
        else $error("discharge not enabled when off");
    dis_clear_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE6]
        clk_en && imaging_ldo_a_control_ff[2:0] != `LSC_CODE_OFF |=>
            !imaging_ldo_a_discharge_ff)
        else $error("discharge on while not off");
    core_reset_a: assert property (@(posedge mclk) // [RULE4]
        sys_rst |=> core_ldo_control_ff == `LSC_CORE_RST)
        else $error("core reset value wrong");
    img_reset_a: assert property (@(posedge mclk) // [RULE5]
        sys_rst |=> imaging_ldo_a_control_ff == `LSC_IMG_A_RST)
        else $error("imaging reset value wrong");
    mode_reset_a: assert property (@(posedge mclk) // [RULE1] [RULE6]
        sys_rst |=> core_ldo_mode_ff == LSC_MODE_OFF && imaging_ldo_a_mode_ff == LSC_MODE_OFF &&
            imaging_ldo_a_discharge_ff)
        else $error("reset modes wrong");
    freeze_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !clk_en |=> $stable(core_ldo_control_ff) && $stable(imaging_ldo_a_control_ff) &&
            $stable(core_ldo_mode_ff) && $stable(reg_rdata_ff))
        else $error("state moved with clock enable low");
endmodule // lsc_ldo_ctrl

// File: bench/lsc_ldo_ctrl_test.sv
// self-checking bench for the regulator state control registers
// assumes lsc_ldo_ctrl, lsc_pkg and lsc_regs.svh on the include path
`include "lsc_regs.svh"
module lsc_ldo_ctrl_test import lsc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, sys_rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, standby_exit_pin = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff;
    logic reg_hit_ff, imaging_ldo_a_discharge_ff;
    lsc_mode_t core_ldo_mode_ff, imaging_ldo_a_mode_ff;
    logic [7:0] m_img = `LSC_IMG_A_RST, m_core = `LSC_CORE_RST;
    int n_fail = 0, n_tests = 0;
    always #5 mclk = ~mclk;
    lsc_ldo_ctrl u_lsc_ldo_ctrl (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_ff(reg_rdata_ff), .reg_hit_ff(reg_hit_ff),
        .standby_exit_pin(standby_exit_pin), .core_ldo_mode_ff(core_ldo_mode_ff),
        .imaging_ldo_a_mode_ff(imaging_ldo_a_mode_ff),
        .imaging_ldo_a_discharge_ff(imaging_ldo_a_discharge_ff));
    // ----------------------------------------
    // expectations and checks
    // ----------------------------------------
    function automatic lsc_mode_t exp_mode(logic [7:0] r);
        case (r[2:0])
            `LSC_CODE_OFF: return LSC_MODE_OFF;
            `LSC_CODE_LOW: return LSC_MODE_LOW;
            3'h6, 3'h7: return LSC_MODE_ACT;
            default: return LSC_MODE_NONE;
        endcase
    endfunction
    task automatic chk(string name, logic [7:0] got, logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // register port and pin drivers
    // ----------------------------------------
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        if (clk_en && a == `LSC_IMG_A_ADDR) m_img = d & `LSC_LIVE_MASK;
        if (clk_en && a == `LSC_CORE_ADDR) m_core = d & `LSC_LIVE_MASK;
    endtask
    task automatic rd(logic [7:0] a);
        logic hit;
        logic [7:0] exp;
        hit = (a == `LSC_IMG_A_ADDR) || (a == `LSC_CORE_ADDR);
        exp = (a == `LSC_IMG_A_ADDR) ? m_img : hit ? m_core : 8'h00;
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk("rdata", reg_rdata_ff, exp);
        chk("hit", {7'h0, reg_hit_ff}, {7'h0, hit});
    endtask
    task automatic chk_modes();
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("core_mode", 8'(core_ldo_mode_ff), 8'(exp_mode(m_core)));
        chk("img_mode", 8'(imaging_ldo_a_mode_ff), 8'(exp_mode(m_img)));
        chk("discharge", {7'h0, imaging_ldo_a_discharge_ff},
            {7'h0, exp_mode(m_img) == LSC_MODE_OFF});
    endtask
    task automatic exit_pulse();
        @(posedge mclk);
        standby_exit_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        standby_exit_pin <= 1'b0;
        if (m_img[5:3] >= 3'h4) m_img[2:0] = m_img[5:3];
        if (m_core[5:3] >= 3'h4) m_core[2:0] = m_core[5:3];
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        logic [7:0] a;
        void'($urandom(32'h5dd3_a34c));
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(`LSC_IMG_A_ADDR);
        rd(`LSC_CORE_ADDR);
        chk_modes();
        for (int c = 0; c < 8; c++) begin
            wr(`LSC_IMG_A_ADDR, 8'(c) | 8'hc0);
            wr(`LSC_CORE_ADDR, 8'(7 - c));
            chk_modes();
        end
        // every exit code, host loads exit fields first
        for (int c = 0; c < 8; c++) begin
            wr(`LSC_IMG_A_ADDR, 8'(c << 3) | 8'h01);
            wr(`LSC_CORE_ADDR, 8'((7 - c) << 3) | 8'h02);
            exit_pulse();
            chk_modes();
            rd(`LSC_IMG_A_ADDR);
            rd(`LSC_CORE_ADDR);
        end
        // write landing on the exit copy edge
        for (int c = 0; c < 2; c++) begin
            fork
                exit_pulse();
                begin
                    repeat (2) @(posedge mclk);
                    wr(`LSC_IMG_A_ADDR, (c != 0) ? 8'h31 : 8'h11);
                end
            join
            chk_modes();
            rd(`LSC_IMG_A_ADDR);
        end
        // writes with the clock enable low are dropped
        @(posedge mclk);
        clk_en <= 1'b0;
        wr(`LSC_IMG_A_ADDR, 8'h3f);
        clk_en <= 1'b1;
        rd(`LSC_IMG_A_ADDR);
        for (int i = 0; i < 40; i++) begin
            case ($urandom % 3)
                0: a = `LSC_IMG_A_ADDR;
                1: a = `LSC_CORE_ADDR;
                default: a = 8'($urandom);
            endcase
            wr(a, 8'($urandom));
            rd(a);
            if ($urandom % 3 == 0) exit_pulse();
            chk_modes();
        end
        // reset in mid-run returns both registers to their defaults
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        m_img = `LSC_IMG_A_RST;
        m_core = `LSC_CORE_RST;
        rd(`LSC_IMG_A_ADDR);
        rd(`LSC_CORE_ADDR);
        chk_modes();
        complete_run();
    end
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
endmodule // lsc_ldo_ctrl_test
